//--- rtl/i2c_bus_flags.sv
/*
  bus flag bits, start request handling and serial clock width timing of a
  two-wire bus unit. assumes byte transfer logic outside supplies data drive and
  stop requests, and that pins are open drain with external pull-ups.
*/
`timescale 1ns/1ps
module i2c_bus_flags #(
  parameter int W = i2c_flags_pkg::WIDTH_DEF
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic flag_wr_in,
  input wire logic [i2c_flags_pkg::REG_W-1:0] flag_wdata_in,
  output logic [i2c_flags_pkg::REG_W-1:0] flag_rdata_out,
  input wire logic ctl_wr_in,
  input wire logic [i2c_flags_pkg::REG_W-1:0] ctl_wdata_in,
  output logic [i2c_flags_pkg::REG_W-1:0] ctl_rdata_out,
  input wire logic [W-1:0] scl_low_width_in,
  input wire logic [W-1:0] scl_high_width_in,
  input wire logic data_low_in,
  input wire logic stop_request_in,
  output logic master_active_out,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_out,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_out
);
  import i2c_flags_pkg::*;

  typedef struct packed {
    mstate_t st;
    logic [W-1:0] cnt;
    logic reservation_disable;
    logic initial_start_enable;
    logic bus_busy_flag;
    logic start_fail_flag;
    logic unit_enable;
    logic start_request;
    logic scl_prev;
    logic sda_prev;
    logic scl_oe;
    logic sda_oe;
  } state_t;

  state_t r;
  state_t n;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;

  pin_sync #(.STAGES(SYNC_STAGES)) u_scl_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .d_in(serial_clock_pin_in),
    .q_out(scl_s)
  );

  pin_sync #(.STAGES(SYNC_STAGES)) u_sda_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .d_in(serial_data_pin_in),
    .q_out(sda_s)
  );

  // data edges while the clock line stays high
  assign start_det = scl_s & r.scl_prev & r.sda_prev & ~sda_s;
  assign stop_det = scl_s & r.scl_prev & ~r.sda_prev & sda_s;

  // a zero width still lasts one cycle
  function automatic logic last_tick(input logic [W-1:0] c);
    return c <= {{(W-1){1'b0}}, 1'b1};
  endfunction

  always_comb begin
    n = r;
    n.scl_prev = scl_s;
    n.sda_prev = sda_s;
    if (flag_wr_in) begin
      // busy and fail positions are not written
      n.reservation_disable = flag_wdata_in[FLAG_RSV_BIT];
      n.initial_start_enable = flag_wdata_in[FLAG_ISE_BIT];
    end
    if (ctl_wr_in) begin
      n.unit_enable = ctl_wdata_in[CTL_UE_BIT];
      if (ctl_wdata_in[CTL_STT_BIT]) begin
        n.start_request = 1'b1;
        n.start_fail_flag = 1'b0;
      end
    end
    if (stop_det) begin
      n.bus_busy_flag = 1'b0;
    end
    if (start_det) begin
      n.bus_busy_flag = 1'b1;
      n.initial_start_enable = 1'b0;
    end
    // enabling with initial start off assumes the bus is taken
    if (!r.unit_enable && n.unit_enable && !r.initial_start_enable) begin
      n.bus_busy_flag = 1'b1;
    end
    unique case (r.st)
      M_IDLE: begin
        if (r.start_request && r.unit_enable) begin
          if (!r.bus_busy_flag) begin
            n.st = M_START;
            n.sda_oe = 1'b1;
            n.cnt = scl_high_width_in;
            n.start_request = 1'b0;
          end else if (r.reservation_disable) begin
            n.start_request = 1'b0;
            n.start_fail_flag = 1'b1;
          end
          // with reservation enabled the request waits for a free bus
        end
      end
      M_START: begin
        n.cnt = r.cnt - 1'b1;
        if (last_tick(r.cnt)) begin
          n.st = M_LOW;
          n.scl_oe = 1'b1;
          n.cnt = scl_low_width_in;
        end
      end
      M_LOW: begin
        n.cnt = r.cnt - 1'b1;
        // data goes low ahead of a stop, a cycle before the clock rises if the request comes before the last low cycle
        n.sda_oe = data_low_in || stop_request_in;
        if (last_tick(r.cnt)) begin
          n.scl_oe = 1'b0;
          n.cnt = scl_high_width_in;
          if (stop_request_in) begin
            n.st = M_STOP;
            n.sda_oe = 1'b1;
          end else begin
            n.st = M_HIGH;
          end
        end
      end
      M_HIGH: begin
        // high time starts once the line has risen, so edges add to the period
        if (scl_s) begin
          n.cnt = r.cnt - 1'b1;
          if (last_tick(r.cnt)) begin
            n.st = M_LOW;
            n.scl_oe = 1'b1;
            n.cnt = scl_low_width_in;
          end
        end
      end
      M_STOP: begin
        if (scl_s) begin
          n.cnt = r.cnt - 1'b1;
          if (last_tick(r.cnt)) begin
            n.st = M_IDLE;
            n.sda_oe = 1'b0;
          end
        end
      end
    endcase
    if (!n.unit_enable) begin
      n.bus_busy_flag = 1'b0;
      n.start_request = 1'b0;
      n.st = M_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      r.st <= M_IDLE;
      r.cnt <= '0;
      r.reservation_disable <= 1'b0;
      r.initial_start_enable <= 1'b0;
      r.bus_busy_flag <= 1'b0;
      r.start_fail_flag <= 1'b0;
      r.unit_enable <= 1'b0;
      r.start_request <= 1'b0;
      r.scl_prev <= PIN_IDLE;
      r.sda_prev <= PIN_IDLE;
      r.scl_oe <= 1'b0;
      r.sda_oe <= 1'b0;
    end else if (ce_in) begin
      r <= n;
    end
  end

  always_comb begin
    flag_rdata_out = REG_ZERO;
    flag_rdata_out[FLAG_RSV_BIT] = r.reservation_disable;
    flag_rdata_out[FLAG_ISE_BIT] = r.initial_start_enable;
    flag_rdata_out[FLAG_BUSY_BIT] = r.bus_busy_flag;
    flag_rdata_out[FLAG_FAIL_BIT] = r.start_fail_flag;
    ctl_rdata_out = REG_ZERO;
    ctl_rdata_out[CTL_UE_BIT] = r.unit_enable;
    ctl_rdata_out[CTL_STT_BIT] = r.start_request;
  end

  assign master_active_out = (r.st != M_IDLE);
  assign serial_clock_pin_out = 1'b0;
  assign serial_clock_pin_oe_out = r.scl_oe;
  assign serial_data_pin_out = 1'b0;
  assign serial_data_pin_oe_out = r.sda_oe;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  sequence low_entry;
    ce_in && r.unit_enable && !ctl_wr_in && r.st == M_START && last_tick(r.cnt);
  endsequence

  rsv_hold_a: assert property (ce_in && !flag_wr_in |=> $stable(r.reservation_disable))
    else $error("reservation disable changed without a write");
  ro_bits_a: assert property (ce_in && flag_wr_in && !ctl_wr_in && r.unit_enable && !start_det
      && !stop_det |=> $stable(r.bus_busy_flag))
    else $error("busy flag moved on a flag write");
  ise_free_a: assert property (ce_in && ctl_wr_in && ctl_wdata_in[CTL_UE_BIT] && !r.unit_enable
      && r.initial_start_enable && !start_det |=> !r.bus_busy_flag)
    else $error("initial start enable did not release the bus");
  busy_set_a: assert property (ce_in && start_det && r.unit_enable && !ctl_wr_in
      |=> r.bus_busy_flag)
    else $error("start not seen as busy");
  busy_clr_a: assert property (ce_in && !r.unit_enable && !ctl_wr_in |=> !r.bus_busy_flag)
    else $error("busy while stopped");
  fail_set_a: assert property (ce_in && r.unit_enable && r.st == M_IDLE && r.start_request
      && r.bus_busy_flag && r.reservation_disable && !ctl_wr_in
      |=> r.start_fail_flag && !r.start_request)
    else $error("failed start not flagged");
  ctl_bits_a: assert property (ce_in && ctl_wr_in
      |=> r.unit_enable == $past(ctl_wdata_in[CTL_UE_BIT]))
    else $error("unit enable not taken from bit 7");
  low_load_a: assert property (low_entry |=> r.st == M_LOW && r.scl_oe
      && r.cnt == $past(scl_low_width_in))
    else $error("low phase not loaded with low width");
  low_count_a: assert property (ce_in && r.unit_enable && !ctl_wr_in && r.st == M_LOW
      && !last_tick(r.cnt) |=> r.st == M_LOW && r.cnt == $past(r.cnt) - 1'b1)
    else $error("low phase count slipped");
  high_wait_a: assert property (ce_in && r.unit_enable && !ctl_wr_in && r.st == M_HIGH
      && !scl_s |=> $stable(r.cnt) && r.st == M_HIGH)
    else $error("high count ran before clock rose");
endmodule

//--- rtl/i2c_flags_pkg.sv
/*
  constants shared by the two-wire bus flag and serial clock timing block.
  assumes nothing beyond a systemverilog compiler.
*/
package i2c_flags_pkg;
  localparam int FLAG_RSV_BIT = 0;
  localparam int FLAG_ISE_BIT = 1;
  localparam int FLAG_BUSY_BIT = 6;
  localparam int FLAG_FAIL_BIT = 7;
  localparam int CTL_STT_BIT = 1;
  localparam int CTL_UE_BIT = 7;
  localparam int REG_W = 8;
  localparam int WIDTH_DEF = 8;
  localparam int SYNC_STAGES = 2;
  localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
  localparam logic PIN_IDLE = 1'b1;
  typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_STOP} mstate_t;
endpackage

//--- rtl/pin_sync.sv
/*
  two-flop synchroniser for one bus pin.
  assumes the pin is asynchronous to clock_in; idles high as a pulled-up line.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int STAGES = i2c_flags_pkg::SYNC_STAGES
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic d_in,
  output logic q_out
);
  import i2c_flags_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0] chain;
  } sync_t;

  sync_t r;
  sync_t n;

  always_comb begin
    n = r;
    n.chain = {r.chain[STAGES-2:0], d_in};
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      r.chain <= {STAGES{PIN_IDLE}};
    end else if (ce_in) begin
      r <= n;
    end
  end

  // only the last stage leaves the module
  assign q_out = r.chain[STAGES-1];
endmodule

//--- testbench/bus_peer.sv
/*
  third party on the two-wire bus: makes start and stop conditions with its own
  160 ns bit clock. assumes open-drain lines with pull-ups resolved by the bench.
*/
`timescale 1ns/1ps
module bus_peer (
  output logic scl_low_out,
  output logic sda_low_out
);
  // its clock stands still between frames, so the lines idle released
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  task start_cond();
    #80 sda_low_out = 1'b1;
    #80 scl_low_out = 1'b1;
    #80;
  endtask
  task stop_cond();
    sda_low_out = 1'b1;
    #80 scl_low_out = 1'b0;
    #80 sda_low_out = 1'b0;
    #80;
  endtask
endmodule

//--- testbench/tb.sv
/*
  self-checking bench of the bus flag and serial clock timing block.
  assumes pull-ups on both lines; ce_in and data_low_in stay tied.
*/
`timescale 1ns/1ps
module tb;
  import i2c_flags_pkg::*;
  logic clock_in, srst_in, flag_wr_in, ctl_wr_in, stop_request_in;
  logic [7:0] flag_wdata_in, ctl_wdata_in, flag_rdata_out, ctl_rdata_out;
  logic [7:0] low_w, high_w;
  logic master_active_out, scl_o, scl_oe, sda_o, sda_oe, peer_scl, peer_sda;
  logic scl_w, sda_w;
  int n_fail, samples_checked, n;
  assign scl_w = !(scl_oe || peer_scl);
  assign sda_w = !(sda_oe || peer_sda);
  i2c_bus_flags #(.W(8)) uut (
    .clock_in(clock_in), .srst_in(srst_in), .ce_in(1'b1),
    .flag_wr_in(flag_wr_in), .flag_wdata_in(flag_wdata_in), .flag_rdata_out(flag_rdata_out),
    .ctl_wr_in(ctl_wr_in), .ctl_wdata_in(ctl_wdata_in), .ctl_rdata_out(ctl_rdata_out),
    .scl_low_width_in(low_w), .scl_high_width_in(high_w), .data_low_in(1'b0),
    .stop_request_in(stop_request_in), .master_active_out(master_active_out),
    .serial_clock_pin_in(scl_w), .serial_clock_pin_out(scl_o),
    .serial_clock_pin_oe_out(scl_oe), .serial_data_pin_in(sda_w),
    .serial_data_pin_out(sda_o), .serial_data_pin_oe_out(sda_oe));
  bus_peer peer (.scl_low_out(peer_scl), .sda_low_out(peer_sda));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task report_and_stop();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task do_reset();
    srst_in = 1'b1;
    repeat (10) @(negedge clock_in);
    srst_in = 1'b0;
  endtask
  // which: 1 = first control register, 0 = bus flag register
  task wr(input logic which, input logic [7:0] d);
    @(negedge clock_in);
    if (which) begin
      ctl_wr_in = 1'b1;
      ctl_wdata_in = d;
    end else begin
      flag_wr_in = 1'b1;
      flag_wdata_in = d;
    end
    @(negedge clock_in);
    flag_wr_in = 1'b0;
    ctl_wr_in = 1'b0;
  endtask
  task wait_oe(input logic lvl);
    n = 0;
    while (scl_oe !== lvl && n < 400) begin
      @(negedge clock_in);
      n++;
    end
    check(8'(n >= 400), 8'h00);
  endtask
  task t_reset_and_flags();
    check(flag_rdata_out, 8'h00);
    check(ctl_rdata_out, 8'h00);
    check({6'h00, scl_oe, sda_oe}, 8'h00);
    // flag bits change on a write while the unit is stopped
    wr(1'b0, 8'hFF);
    check(flag_rdata_out, 8'h03);
    wr(1'b0, 8'h00);
    check(flag_rdata_out, 8'h00);
    wr(1'b0, 8'h01);
    do_reset();
    check(flag_rdata_out, 8'h00);
  endtask
  task t_busy_and_fail();
    wr(1'b1, 8'h80);
    check(ctl_rdata_out, 8'h80);
    check(flag_rdata_out, 8'h40);
    wr(1'b1, 8'h00);
    check(flag_rdata_out, 8'h00);
    wr(1'b0, 8'h01);
    wr(1'b1, 8'h80);
    wr(1'b1, 8'h82);
    @(negedge clock_in);
    check(flag_rdata_out, 8'hC1);
    check(ctl_rdata_out, 8'h80);
    wr(1'b1, 8'h00);
    check(flag_rdata_out, 8'h81);
    wr(1'b0, 8'h00);
    // a new request clears the fail flag; reservation enabled so it waits
    wr(1'b1, 8'h82);
    check(flag_rdata_out, 8'h40);
    check(ctl_rdata_out, 8'h82);
    do_reset();
  endtask
  task t_own_clock();
    // no other party on the bus, so a start without a stop is safe
    wr(1'b0, 8'h02);
    wr(1'b1, 8'h80);
    check(flag_rdata_out, 8'h02);
    // rewrites the current bits only, so no setting changes while running
    wr(1'b0, 8'hC2);
    check(flag_rdata_out, 8'h02);
    wr(1'b1, 8'h82);
    wait_oe(1'b1);
    check({7'h00, master_active_out}, 8'h01);
    check({6'h00, scl_o, sda_o}, 8'h00);
    wait_oe(1'b0);
    check(8'(n), low_w);
    wait_oe(1'b1);
    // the high phase also spans the pin synchroniser delay
    check(8'(n >= high_w && n <= high_w + SYNC_STAGES + 2), 8'h01);
    check(flag_rdata_out, 8'h40);
    stop_request_in = 1'b1;
    n = 0;
    while (master_active_out !== 1'b0 && n < 400) begin
      @(negedge clock_in);
      n++;
    end
    check(8'(n >= 400), 8'h00);
    stop_request_in = 1'b0;
    repeat (8) @(negedge clock_in);
    check(flag_rdata_out, 8'h00);
    check({6'h00, scl_oe, sda_oe}, 8'h00);
    wr(1'b1, 8'h00);
  endtask
  task t_third_party();
    do_reset();
    wr(1'b1, 8'h80);
    peer.start_cond();
    peer.stop_cond();
    repeat (6) @(negedge clock_in);
    check(flag_rdata_out, 8'h00);
    peer.start_cond();
    repeat (6) @(negedge clock_in);
    check(flag_rdata_out, 8'h40);
    // rewrites the current bits only, so no setting changes while running
    wr(1'b0, 8'h00);
    check(flag_rdata_out, 8'h40);
    wr(1'b1, 8'h82);
    repeat (20) @(negedge clock_in);
    // reservation enabled: the request waits for a free bus
    check(ctl_rdata_out, 8'h82);
    check({7'h00, sda_oe}, 8'h00);
    peer.stop_cond();
    // the stop frees the bus, so the held request goes out
    check({7'h00, master_active_out}, 8'h01);
    check(ctl_rdata_out, 8'h80);
    wr(1'b1, 8'h00);
    check(ctl_rdata_out, 8'h00);
  endtask
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    n_fail = 0;
    samples_checked = 0;
    flag_wr_in = 1'b0;
    ctl_wr_in = 1'b0;
    flag_wdata_in = 8'h00;
    ctl_wdata_in = 8'h00;
    stop_request_in = 1'b0;
    // software picks the widths; the block only counts them
    low_w = 8'h06;
    high_w = 8'h05;
    do_reset();
    t_reset_and_flags();
    t_busy_and_fail();
    t_own_clock();
    t_third_party();
    report_and_stop();
  end
endmodule
